// *** hw/tuner_map.svh ***
// Register offsets, field positions, reset values and counts of the tuner port block.
`ifndef TUNER_MAP_SVH
`define TUNER_MAP_SVH

// ********************************************************************
// Register offsets
// ********************************************************************
`define ADDR_INPUT_OFFSET_HIGH   8'h07
`define ADDR_INPUT_OFFSET_LOW    8'h08
`define ADDR_AUX_PORT_CONTROL    8'h14
`define ADDR_FREQ_SEARCH_RANGE   8'h25
`define ADDR_FREQ_SEARCH_OFFSET  8'h26
`define ADDR_MIXER_OFFSET_HIGH   8'h6f
`define ADDR_MIXER_OFFSET_MID    8'h70
`define ADDR_MIXER_OFFSET_LOW    8'h71
`define ADDR_CARRIER_OFFSET_HIGH 8'h72
`define ADDR_CARRIER_OFFSET_LOW  8'h73

// ********************************************************************
// Reset values
// ********************************************************************
`define AUX_CTRL_RESET_PASS      1'h0
`define AUX_CTRL_RESET_DIR       3'h4
`define AUX_CTRL_RESET_VALUE     3'h0
`define RANGE_RESET              7'h30
`define OFFSET_RESET             8'h00
`define READ_UNMAPPED            8'h00

// ********************************************************************
// Field positions and codes
// ********************************************************************
`define AUX_PASS_BIT             6
`define AUX_DIR_MSB              5
`define AUX_DIR_LSB              3
`define AUX_VALUE_MSB            2
`define AUX_VALUE_LSB            0
`define AUX_PASS_PINS            2
`define RANGE_MSB                6
`define RANGE_UNIT_SHIFT         2
`define IRQ_LOW_BAUD_END_BIT     6
`define STAT_HIGH_LOCK_BIT       0
`define DEC_BYTE_LOCK_BIT        2
`define DEC_CODE_RATE_MSB        6
`define DEC_CODE_RATE_LSB        4
`define READBACK_SYMBOL_RATE     8'h03
`define CODE_RATE_6_7_BIT        4
`define FOUND_RATE_DROP_LSB      2

// ********************************************************************
// Timing counts
// ********************************************************************
`define BRIDGE_SETTLE_LAST       2'h3

`endif

// *** hw/tuner_pkg.sv ***
// Types shared by the tuner port block.
`default_nettype none
package tuner_pkg;

  // ******************************************************************
  // Carriers
  // ******************************************************************
  typedef struct packed {
    logic        demod_locked;
    logic        search_exhausted;
    logic [15:0] found_symbol_rate;
    logic [15:0] input_offset;
    logic [23:0] mixer_offset;
    logic [15:0] carrier_offset;
  } demod_result_t;

  typedef struct packed {
    logic       byte_align_lock;
    logic [2:0] code_rate;
  } decoder_result_t;

  typedef struct packed {
    logic signed [10:0] low;
    logic signed [10:0] high;
  } search_window_t;

  // ******************************************************************
  // Pass-through line states
  // ******************************************************************
  typedef enum logic [3:0] {
    BR_IDLE       = 4'h1,
    BR_TO_AUX     = 4'h2,
    BR_TO_PRIMARY = 4'h4,
    BR_SETTLE     = 4'h8
  } bridge_state_t;

endpackage : tuner_pkg
`default_nettype wire

// *** hw/passthrough_line.sv ***
// One open-drain line of the bus pass-through between primary and auxiliary pins.
`timescale 1ns/100ps
`default_nettype none
`include "tuner_map.svh"

module passthrough_line (
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // Control
  input  wire logic enable_in,
  // Synchronised line levels
  input  wire logic aux_level_in,
  input  wire logic primary_level_in,
  // Drive requests
  output logic      drive_aux_low_out,
  output logic      drive_primary_low_out
);

  tuner_pkg::bridge_state_t state_q;
  tuner_pkg::bridge_state_t state_d;
  logic [1:0]               settle_q;

  // ******************************************************************
  // Direction arbitration
  // ******************************************************************
  // The side pulled low first is mirrored; our own drive is never fed back.
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      tuner_pkg::BR_IDLE:
        if (enable_in && !primary_level_in)
          state_d = tuner_pkg::BR_TO_AUX;
        else if (enable_in && !aux_level_in)
          state_d = tuner_pkg::BR_TO_PRIMARY;
      tuner_pkg::BR_TO_AUX:
        if (!enable_in || primary_level_in)
          state_d = tuner_pkg::BR_SETTLE;
      tuner_pkg::BR_TO_PRIMARY:
        if (!enable_in || aux_level_in)
          state_d = tuner_pkg::BR_SETTLE;
      tuner_pkg::BR_SETTLE:
        if (settle_q == `BRIDGE_SETTLE_LAST)
          state_d = tuner_pkg::BR_IDLE;
      default:
        state_d = tuner_pkg::BR_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      state_q <= tuner_pkg::BR_IDLE;
    else
      state_q <= state_d;
  end

  // Released lines need the synchroniser delay to read high again.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in || state_q != tuner_pkg::BR_SETTLE)
      settle_q <= 2'h0;
    else
      settle_q <= settle_q + 2'h1;
  end

  assign drive_aux_low_out     = (state_q == tuner_pkg::BR_TO_AUX);
  assign drive_primary_low_out = (state_q == tuner_pkg::BR_TO_PRIMARY);

  AST_BRIDGE_ONE_WAY: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    !(drive_aux_low_out && drive_primary_low_out))
    else $error("Pass-through drives both sides at once.");

  AST_BRIDGE_RELEASE: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    !enable_in |=> !drive_aux_low_out && !drive_primary_low_out)
    else $error("Pass-through keeps driving after disable.");

endmodule : passthrough_line
`default_nettype wire

// *** hw/tuner_port_and_freq_search.sv ***
// Tuner port, frequency search window and offset readout of the demodulator.
`timescale 1ns/100ps
`default_nettype none
`include "tuner_map.svh"


module tuner_port_and_freq_search (
  // Clock and reset
  input  wire logic                       mclk_in,
  input  wire logic                       rst_in,
  // Register access
  input  wire logic [7:0]                 reg_addr_in,
  input  wire logic [7:0]                 reg_wdata_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  output logic      [7:0]                 reg_rdata_out,
  // Auxiliary pins
  input  wire logic [2:0]                 aux_pin_in,
  output logic      [2:0]                 aux_pin_out,
  output logic      [2:0]                 aux_pin_oe_out,
  // Primary serial bus lines
  input  wire logic                       primary_bus_data_in,
  output logic                            primary_bus_data_out,
  output logic                            primary_bus_data_oe_out,
  input  wire logic                       primary_bus_clock_in,
  output logic                            primary_bus_clock_out,
  output logic                            primary_bus_clock_oe_out,
  // Demodulator and decoder core
  input  wire tuner_pkg::demod_result_t   demod_in,
  input  wire tuner_pkg::decoder_result_t decoder_in,
  input  wire logic                       dvb_mode_in,
  input  wire logic [7:0]                 code_rate_select_in,
  input  wire logic [7:0]                 readback_select_in,
  input  wire logic                       baud_end_clear_in,
  // Search control and status
  output var  tuner_pkg::search_window_t  search_window_out,
  output logic      [7:0]                 code_rate_search_out,
  output logic                            code_rate_search_forced_out,
  output logic      [7:0]                 demod_irq_low_out,
  output logic      [7:0]                 demod_status_high_out,
  output logic      [7:0]                 decoder_lock_status_out,
  output logic      [15:0]                monitor_readback_out,
  output logic      [13:0]                reacq_symbol_rate_out
);

  // ******************************************************************
  // Declarations
  // ******************************************************************
  logic                      pass_q;
  logic [2:0]                dir_q;
  logic [2:0]                pin_value_q;
  logic [6:0]                range_q;
  logic [7:0]                offset_q;
  logic [2:0]                aux_meta_q;
  logic [2:0]                aux_sync_q;
  logic [1:0]                prim_meta_q;
  logic [1:0]                prim_sync_q;
  logic [1:0]                drive_aux_low;
  logic [1:0]                drive_prim_low;
  logic [1:0]                prim_oe_q;
  logic [15:0]               input_offset_q;
  logic [15:0]               mixer_snap_q;
  logic [15:0]               carrier_snap_q;
  logic                      baud_end_q;
  logic                      ctrl_wr;
  logic [2:0]                dir_next;
  logic                      pass_next;
  logic [10:0]               range_span;
  logic [10:0]               offset_wide;
  logic [7:0]                rdata_q;
  logic [7:0]                rate_mask;
  tuner_pkg::search_window_t window_q;

  assign ctrl_wr   = reg_wr_in && (reg_addr_in == `ADDR_AUX_PORT_CONTROL);
  assign dir_next  = ctrl_wr ? reg_wdata_in[`AUX_DIR_MSB:`AUX_DIR_LSB] : dir_q;
  assign pass_next = ctrl_wr ? reg_wdata_in[`AUX_PASS_BIT] : pass_q;

  // ******************************************************************
  // Pin synchronisers
  // ******************************************************************
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      aux_meta_q  <= 3'h7;
      aux_sync_q  <= 3'h7;
      prim_meta_q <= 2'h3;
      prim_sync_q <= 2'h3;
    end
    else
    begin
      aux_meta_q  <= aux_pin_in;
      aux_sync_q  <= aux_meta_q;
      prim_meta_q <= {primary_bus_data_in, primary_bus_clock_in};
      prim_sync_q <= prim_meta_q;
    end
  end

  // ******************************************************************
  // Port control register
  // ******************************************************************
  // The reserved top bit is not stored and reads back as zero.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      pass_q <= `AUX_CTRL_RESET_PASS;
      dir_q  <= `AUX_CTRL_RESET_DIR;
    end
    else if (ctrl_wr)
    begin
      pass_q <= reg_wdata_in[`AUX_PASS_BIT];
      dir_q  <= reg_wdata_in[`AUX_DIR_MSB:`AUX_DIR_LSB];
    end
  end

  // Input pins, and pins 0 and 1 in pass-through, follow the pin; other output pins hold the written level.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      pin_value_q <= `AUX_CTRL_RESET_VALUE;
    else
      for (int n = 0; n < 3; n++)
      begin
        if ((pass_next && n < `AUX_PASS_PINS) || !dir_next[n])
          pin_value_q[n] <= aux_sync_q[n];
        else if (ctrl_wr)
          pin_value_q[n] <= reg_wdata_in[n];
      end
  end

  // ******************************************************************
  // Pass-through and pin drivers
  // ******************************************************************
  passthrough_line u_data_line (
    .mclk_in               (mclk_in),
    .rst_in                (rst_in),
    .enable_in             (pass_q),
    .aux_level_in          (aux_sync_q[1]),
    .primary_level_in      (prim_sync_q[1]),
    .drive_aux_low_out     (drive_aux_low[1]),
    .drive_primary_low_out (drive_prim_low[1])
  );

  passthrough_line u_clock_line (
    .mclk_in               (mclk_in),
    .rst_in                (rst_in),
    .enable_in             (pass_q),
    .aux_level_in          (aux_sync_q[0]),
    .primary_level_in      (prim_sync_q[0]),
    .drive_aux_low_out     (drive_aux_low[0]),
    .drive_primary_low_out (drive_prim_low[0])
  );

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      aux_pin_out    <= 3'h0;
      aux_pin_oe_out <= 3'h0;
    end
    else
      for (int n = 0; n < 3; n++)
      begin
        if (pass_q && n < `AUX_PASS_PINS)
        begin
          aux_pin_out[n]    <= 1'b0;
          aux_pin_oe_out[n] <= drive_aux_low[n];
        end
        else
        begin
          aux_pin_out[n]    <= pin_value_q[n];
          aux_pin_oe_out[n] <= dir_q[n];
        end
      end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      prim_oe_q <= 2'h0;
    else
      prim_oe_q <= drive_prim_low;
  end

  assign primary_bus_data_out     = 1'b0;
  assign primary_bus_clock_out    = 1'b0;
  assign primary_bus_data_oe_out  = prim_oe_q[1];
  assign primary_bus_clock_oe_out = prim_oe_q[0];

  // ******************************************************************
  // Frequency search window
  // ******************************************************************
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      range_q  <= `RANGE_RESET;
      offset_q <= `OFFSET_RESET;
    end
    else if (reg_wr_in && reg_addr_in == `ADDR_FREQ_SEARCH_RANGE)
      range_q <= reg_wdata_in[`RANGE_MSB:0];
    else if (reg_wr_in && reg_addr_in == `ADDR_FREQ_SEARCH_OFFSET)
      offset_q <= reg_wdata_in;
  end

  // Range is rescaled from eighths to thirty-seconds of a MHz.
  assign range_span  = {4'h0, range_q} << `RANGE_UNIT_SHIFT;
  assign offset_wide = {{3{offset_q[7]}}, offset_q};

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      window_q <= '0;
    else
    begin
      window_q.low  <= $signed(offset_wide - range_span);
      window_q.high <= $signed(offset_wide + range_span);
    end
  end

  assign search_window_out = window_q;

  // ******************************************************************
  // Offset measurements
  // ******************************************************************
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      input_offset_q <= 16'h0000;
    else if (demod_in.demod_locked)
      input_offset_q <= demod_in.input_offset;
  end

  // Reading the coarse high byte freezes the other four error bytes.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      mixer_snap_q   <= 16'h0000;
      carrier_snap_q <= 16'h0000;
    end
    else if (reg_rd_in && reg_addr_in == `ADDR_MIXER_OFFSET_HIGH)
    begin
      mixer_snap_q   <= demod_in.mixer_offset[15:0];
      carrier_snap_q <= demod_in.carrier_offset;
    end
  end

  // ******************************************************************
  // Register read
  // ******************************************************************
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      rdata_q <= `READ_UNMAPPED;
    else if (reg_rd_in)
      unique case (reg_addr_in)
        `ADDR_INPUT_OFFSET_HIGH:   rdata_q <= input_offset_q[15:8];
        `ADDR_INPUT_OFFSET_LOW:    rdata_q <= input_offset_q[7:0];
        `ADDR_AUX_PORT_CONTROL:    rdata_q <= {1'b0, pass_q, dir_q, pin_value_q};
        `ADDR_FREQ_SEARCH_RANGE:   rdata_q <= {1'b0, range_q};
        `ADDR_FREQ_SEARCH_OFFSET:  rdata_q <= offset_q;
        `ADDR_MIXER_OFFSET_HIGH:   rdata_q <= demod_in.mixer_offset[23:16];
        `ADDR_MIXER_OFFSET_MID:    rdata_q <= mixer_snap_q[15:8];
        `ADDR_MIXER_OFFSET_LOW:    rdata_q <= mixer_snap_q[7:0];
        `ADDR_CARRIER_OFFSET_HIGH: rdata_q <= carrier_snap_q[15:8];
        `ADDR_CARRIER_OFFSET_LOW:  rdata_q <= carrier_snap_q[7:0];
        default:                   rdata_q <= `READ_UNMAPPED;
      endcase
  end

  assign reg_rdata_out = rdata_q;

  // ******************************************************************
  // Search results and status
  // ******************************************************************
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      baud_end_q <= 1'b0;
    else if (demod_in.search_exhausted)
      baud_end_q <= 1'b1;
    else if (baud_end_clear_in)
      baud_end_q <= 1'b0;
  end

  assign rate_mask = 8'h01 << `CODE_RATE_6_7_BIT;

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      code_rate_search_out        <= 8'h00;
      code_rate_search_forced_out <= 1'b0;
      demod_status_high_out       <= 8'h00;
      decoder_lock_status_out     <= 8'h00;
      monitor_readback_out        <= 16'h0000;
      reacq_symbol_rate_out       <= 14'h0000;
    end
    else
    begin
      code_rate_search_out <= dvb_mode_in ? (code_rate_select_in & ~rate_mask)
                                          : code_rate_select_in;
      code_rate_search_forced_out <=
        (code_rate_select_in & (code_rate_select_in - 8'h01)) != 8'h00;
      demod_status_high_out <= 8'h00;
      demod_status_high_out[`STAT_HIGH_LOCK_BIT] <= demod_in.demod_locked;
      decoder_lock_status_out <= 8'h00;
      decoder_lock_status_out[`DEC_BYTE_LOCK_BIT] <= decoder_in.byte_align_lock;
      decoder_lock_status_out[`DEC_CODE_RATE_MSB:`DEC_CODE_RATE_LSB] <=
        decoder_in.byte_align_lock ? decoder_in.code_rate : 3'h0;
      monitor_readback_out <= (readback_select_in == `READBACK_SYMBOL_RATE)
                              ? demod_in.found_symbol_rate : 16'h0000;
      reacq_symbol_rate_out <= demod_in.found_symbol_rate[15:`FOUND_RATE_DROP_LSB];
    end
  end

  always_comb
  begin
    demod_irq_low_out = 8'h00;
    demod_irq_low_out[`IRQ_LOW_BAUD_END_BIT] = baud_end_q;
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  AST_PASS_IGNORES_DIR: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    pass_q && !drive_aux_low[0] |=> !aux_pin_oe_out[0])
    else $error("Aux pin 0 driven in pass-through without request.");

  AST_PIN2_DIR_IN_PASS: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    pass_q |=> aux_pin_oe_out[2] == $past(dir_q[2]))
    else $error("Aux pin 2 direction lost in pass-through.");

  AST_OUTPUT_DRIVES_VALUE: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    !pass_q && dir_q[0] |=> aux_pin_oe_out[0] && aux_pin_out[0] == $past(pin_value_q[0]))
    else $error("Output pin 0 does not show its value bit.");

  AST_INPUT_RELEASED: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    !pass_q && !dir_q[2] |=> !aux_pin_oe_out[2])
    else $error("Input pin 2 is being driven.");

  AST_INPUT_FOLLOWS: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    !pass_q && !dir_q[1] && !ctrl_wr |=> pin_value_q[1] == $past(aux_sync_q[1]))
    else $error("Input pin 1 value bit does not follow the pin.");

  AST_RESET_STATE: assert property (
    @(posedge mclk_in)
    $past(rst_in) |-> !pass_q && dir_q == `AUX_CTRL_RESET_DIR && !pin_value_q[2] &&
      range_q == `RANGE_RESET)
    else $error("Port control or range not at reset value.");

  AST_WINDOW_SPAN: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    $stable(range_q) && $stable(offset_q) |=>
      window_q.high - window_q.low == {2'h0, $past(range_q), 2'h0} + {2'h0, $past(range_q), 2'h0})
    else $error("Search window width is not twice the range.");

  AST_OFFSET_HOLD_UNLOCKED: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    !demod_in.demod_locked |=> $stable(input_offset_q))
    else $error("Input offset changed while unlocked.");

  AST_BLOCK_READ_FROZEN: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    reg_rd_in && reg_addr_in == `ADDR_MIXER_OFFSET_HIGH |=>
      carrier_snap_q == $past(demod_in.carrier_offset))
    else $error("Error bytes not captured with the coarse high byte.");

  AST_NO_6_7_IN_DVB: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    dvb_mode_in |=> !code_rate_search_out[`CODE_RATE_6_7_BIT])
    else $error("Code rate 6/7 searched in DVB mode.");

  AST_BAUD_END_STICKY: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    demod_in.search_exhausted |=> demod_irq_low_out[`IRQ_LOW_BAUD_END_BIT] ##1
      (demod_irq_low_out[`IRQ_LOW_BAUD_END_BIT] || $past(baud_end_clear_in)))
    else $error("Baud-end flag not raised or lost without a clear.");

  AST_CODE_RATE_GATED: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    !decoder_in.byte_align_lock |=> decoder_lock_status_out[6:4] == 3'h0 && !decoder_lock_status_out[2])
    else $error("Code rate shown without decoder lock.");

endmodule : tuner_port_and_freq_search
`default_nettype wire

// *** bench/tuner_side_model.sv ***
// Pin model of the tuner synthesiser on the auxiliary pins.
`timescale 1ns/100ps
`default_nettype none
module tuner_side_model (
  // Pin drivers
  input  wire logic [2:0] dut_val_in,
  input  wire logic [2:0] dut_oe_in,
  input  wire logic [2:0] ext_val_in,
  input  wire logic [2:0] ext_oe_in,
  // Resolved levels
  output logic      [2:0] pin_out
);
  // Undriven pins are pulled up.
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      pin_out[i] = dut_oe_in[i] ? dut_val_in[i] : (ext_oe_in[i] ? ext_val_in[i] : 1'b1);
  end
endmodule : tuner_side_model
`default_nettype wire

// *** bench/test_tuner_port_and_freq_search.sv ***
// Self-checking bench of the tuner port block.
`timescale 1ns/100ps
`default_nettype none
module test_tuner_port_and_freq_search;
  logic mclk_in = 0, rst_in = 1, wr = 0, rd = 0, hd = 0, dvb = 1, clr = 0;
  logic [7:0] adr = 0, wd = 0, rdat, cs = 0, rs = 0, irq, st, ds, cro;
  logic [2:0] ao, aoe, ev = 0, eo = 7, ap;
  logic pdo, pdoe, pco, pcoe, frc;
  logic [15:0] mon;
  logic [13:0] rq;
  logic [31:0] lf = 32'hea6ac40e;
  tuner_pkg::demod_result_t dm = '0;
  tuner_pkg::decoder_result_t dc = '0;
  tuner_pkg::search_window_t sw;
  int n_errors = 0, n_checks = 0, cyc = 0;
  tuner_side_model u_tun (.dut_val_in(ao), .dut_oe_in(aoe), .ext_val_in(ev), .ext_oe_in(eo),
    .pin_out(ap));
  tuner_port_and_freq_search u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(adr),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .aux_pin_in(ap),
    .aux_pin_out(ao), .aux_pin_oe_out(aoe), .primary_bus_data_in(~(hd | pdoe)),
    .primary_bus_data_out(pdo), .primary_bus_data_oe_out(pdoe), .primary_bus_clock_in(~pcoe),
    .primary_bus_clock_out(pco), .primary_bus_clock_oe_out(pcoe), .demod_in(dm),
    .decoder_in(dc), .dvb_mode_in(dvb), .code_rate_select_in(cs), .readback_select_in(rs),
    .baud_end_clear_in(clr), .search_window_out(sw), .code_rate_search_out(cro),
    .code_rate_search_forced_out(frc), .demod_irq_low_out(irq), .demod_status_high_out(st),
    .decoder_lock_status_out(ds), .monitor_readback_out(mon), .reacq_symbol_rate_out(rq));
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction : rnd
  function automatic logic [10:0] exp_low(input logic [7:0] off, input logic [6:0] rng);
    return {{3{off[7]}}, off} - {2'b00, rng, 2'b00};
  endfunction : exp_low
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask : wreg
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_in);
    adr <= a;
    rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    repeat (2) @(posedge mclk_in);
    #1 chk("rdata", e, rdat);
  endtask : rchk
  task automatic give_verdict();
    if (n_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  initial
  begin
    forever #5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  initial
  begin
    logic [31:0] v;
    logic [15:0] fs;
    logic [10:0] lo;
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    repeat (5) @(posedge mclk_in);
    #1 chk("aux_pins", 6'h20, {aoe, ao});
    chk("idle_outs", 19'h0, {pdo, pco, frc, mon});
    rchk(8'h14, 8'h20);
    rchk(8'h25, 8'h30);
    rchk(8'h26, 8'h00);
    rchk(8'h01, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      v = rnd();
      @(posedge mclk_in) ev <= v[31:29];
      wreg(8'h14, {2'b00, v[5:0]});
      wreg(8'h25, {1'b0, v[14:8]});
      wreg(8'h26, v[23:16]);
      repeat (5) @(posedge mclk_in);
      lo = exp_low(v[23:16], v[14:8]);
      #1 chk("win_low", lo, $unsigned(sw.low));
      chk("win_high", 11'(lo + {1'b0, v[14:8], 3'b000}), $unsigned(sw.high));
      chk("aux_oe", v[5:3], aoe);
      chk("aux_out", v[2:0] & v[5:3], ao & aoe);
      rchk(8'h14, {2'b00, v[5:3], (v[2:0] & v[5:3]) | (v[31:29] & ~v[5:3])});
      rchk(8'h25, {1'b0, v[14:8]});
    end
    wreg(8'h14, 8'h78);
    @(posedge mclk_in) eo <= 3'h0;
    repeat (8) @(posedge mclk_in);
    #1 chk("pass_idle", 5'h04, {pdoe, pcoe, aoe});
    @(posedge mclk_in) hd <= 1'b1;
    repeat (6) @(posedge mclk_in);
    #1 chk("pass_data", 7'h30, {pdoe, aoe, ao & aoe});
    @(posedge mclk_in) hd <= 1'b0;
    repeat (10) @(posedge mclk_in);
    eo <= 3'h1;
    ev <= 3'h0;
    repeat (6) @(posedge mclk_in);
    #1 chk("pass_clock", 5'h0c, {pdoe, pcoe, aoe});
    @(posedge mclk_in) eo <= 3'h0;
    repeat (10) @(posedge mclk_in);
    #1 chk("pass_free", 5'h04, {pdoe, pcoe, aoe});
    wreg(8'h14, 8'h00);
    v = rnd();
    fs = 16'(rnd());
    @(posedge mclk_in)
    begin
      dm <= {2'b11, fs, ~fs, v[23:0], v[31:16]};
      dc <= {1'b1, v[2:0]};
      cs <= 8'hff;
      rs <= 8'h03;
    end
    @(posedge mclk_in) dm.search_exhausted <= 1'b0;
    repeat (3) @(posedge mclk_in);
    #1 chk("irq", 8'h40, irq);
    chk("status", {8'h01, fs}, {st, mon});
    chk("reacq", fs[15:2], rq);
    chk("decoder", {1'b0, v[2:0], 4'h4}, ds);
    chk("code_search", 9'h1ef, {frc, cro});
    chk("aux_oe", 3'h0, aoe);
    for (int k = 0; k < 2; k++)
      rchk(8'h07 + 8'(k), 8'(~fs >> (8 - 8 * k)));
    for (int k = 0; k < 5; k++)
      rchk(8'h6f + 8'(k), 8'({v[23:0], v[31:16]} >> (32 - 8 * k)));
    @(posedge mclk_in) clr <= 1'b1;
    @(posedge mclk_in)
    begin
      clr <= 1'b0;
      dvb <= 1'b0;
    end
    repeat (3) @(posedge mclk_in);
    #1 chk("irq_clear", 9'h0ff, {irq, cro});
    give_verdict();
  end
endmodule : test_tuner_port_and_freq_search
`default_nettype wire
